//--- rtl/pss_top.sv
// PID supervisory logic: deviation and band flags, feedback monitor, clear and sleep.
// Contract
// - Deviation flag when magnitude exceeds limit level.
// - Limit level 0 to 100 of target.
// - Output selector code 04 carries deviation flag.
// - Output selector code 31 carries band flag.
// - Monitor equals feedback times display scale.
// - Input selector code 24 marks integral clear.
// - Clear integrator on each integral clear rise.
// - Stop output after command below threshold.
// - Restart after command above wake threshold.
// - Early crossing back abandons the pending delay.
// - Without PID, frequency command drives sleep.
// - Sleep delay 0.0 to 25.5 seconds.
// - Band off and on levels 0 to 100.
// - Sleep threshold 0.0 to 400.0 Hz.
//
// The address-and-strobe port and the placing of the registers were decided locally.
module pss_top #(
  parameter int NUM_IN = 5,
  parameter int TICKS_PER_TENTH = 100,
  parameter int CNT_W = 16
) (
  // Clock, reset and freeze
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Register port
  input pss_pkg::pss_bus_req_s i_bus,
  output logic [pss_pkg::DATA_W-1:0] o_rdata,
  // Control tick and process values
  input wire logic i_tick,
  input wire logic i_pid_enable,
  input wire logic signed [pss_pkg::VAL_W:0] i_deviation,
  input wire logic [pss_pkg::VAL_W-1:0] i_feedback,
  input wire logic [pss_pkg::VAL_W-1:0] i_pid_cmd,
  input wire logic [pss_pkg::VAL_W-1:0] i_freq_cmd,
  // Terminals
  input wire logic [NUM_IN-1:0] i_terminals,
  output logic o_dout,
  output logic o_relay,
  // Process results
  output logic o_integral_clear,
  output logic o_run_enable,
  output pss_pkg::pss_status_s o_status,
  output logic [pss_pkg::MON_W-1:0] o_feedback_monitor
);
  import pss_pkg::*;

  logic [DEV_LVL_W-1:0] dev_lvl_reg, dev_lvl_next;
  logic [FB_LVL_W-1:0] fb_off_reg, fb_off_next;
  logic [FB_LVL_W-1:0] fb_on_reg, fb_on_next;
  logic [SCALE_W-1:0] scale_reg, scale_next;
  logic [HZ_W-1:0] sleep_thr_reg, sleep_thr_next;
  logic [HZ_W-1:0] wake_thr_reg, wake_thr_next;
  logic [DLY_W-1:0] dly_reg, dly_next;
  logic [SEL_W-1:0] out_sel_reg, out_sel_next;
  logic [SEL_W-1:0] relay_sel_reg, relay_sel_next;
  logic [SEL_W-1:0] in_sel_reg [NUM_IN];
  logic [SEL_W-1:0] in_sel_next [NUM_IN];
  logic [DATA_W-1:0] rdata_next;

  pss_status_s stat_reg, stat_next;
  logic dout_next;
  logic relay_next;
  logic clr_prev_reg, clr_prev_next;
  logic clr_pulse_next;
  logic [MON_W-1:0] mon_next;

  logic [VAL_W:0] dev_mag;
  logic [VAL_W:0] dev_lim_val;
  logic dev_over;
  logic [VAL_W-1:0] fb_on_val;
  logic [VAL_W-1:0] fb_off_val;
  logic [NUM_IN-1:0] clr_mask;
  logic clr_level;
  logic [VAL_W-1:0] cmd_sel;
  logic sleep_cond;
  logic wake_cond;
  logic sleep_go;
  logic wake_go;
  logic [CNT_W-1:0] dly_ticks;

  // Register write, saturation of settings and read mux.
  always_comb
  begin
    dev_lvl_next = dev_lvl_reg;
    fb_off_next = fb_off_reg;
    fb_on_next = fb_on_reg;
    scale_next = scale_reg;
    sleep_thr_next = sleep_thr_reg;
    wake_thr_next = wake_thr_reg;
    dly_next = dly_reg;
    out_sel_next = out_sel_reg;
    relay_sel_next = relay_sel_reg;
    in_sel_next = in_sel_reg;
    rdata_next = '0;
    if (i_bus.we)
    begin
      case (i_bus.addr)
        OFS_DEV_LEVEL:
          dev_lvl_next = (i_bus.wdata > DATA_W'(DEV_LVL_MAX)) ? DEV_LVL_MAX
            : i_bus.wdata[DEV_LVL_W-1:0];
        OFS_FB_OFF:
          fb_off_next = (i_bus.wdata > DATA_W'(FB_LVL_MAX)) ? FB_LVL_MAX
            : i_bus.wdata[FB_LVL_W-1:0];
        OFS_FB_ON:
          fb_on_next = (i_bus.wdata > DATA_W'(FB_LVL_MAX)) ? FB_LVL_MAX
            : i_bus.wdata[FB_LVL_W-1:0];
        OFS_PV_SCALE:
          if (i_bus.wdata > DATA_W'(SCALE_MAX))
            scale_next = SCALE_MAX;
          else if (i_bus.wdata < DATA_W'(SCALE_MIN))
            scale_next = SCALE_MIN;
          else
            scale_next = i_bus.wdata[SCALE_W-1:0];
        OFS_SLEEP_THR:
          sleep_thr_next = (i_bus.wdata > DATA_W'(HZ_MAX)) ? HZ_MAX
            : i_bus.wdata[HZ_W-1:0];
        OFS_WAKE_THR:
          wake_thr_next = (i_bus.wdata > DATA_W'(HZ_MAX)) ? HZ_MAX
            : i_bus.wdata[HZ_W-1:0];
        OFS_SLEEP_DLY:
          dly_next = (i_bus.wdata > DATA_W'(DLY_MAX)) ? DLY_MAX
            : i_bus.wdata[DLY_W-1:0];
        OFS_OUT_SEL:
        begin
          out_sel_next = i_bus.wdata[OUT_SEL_LSB +: SEL_W];
          relay_sel_next = i_bus.wdata[RELAY_SEL_LSB +: SEL_W];
        end
        default:
        begin
          for (int k = 0; k < NUM_IN; k++)
          begin
            if (i_bus.addr == ADDR_W'(OFS_IN_SEL_BASE + OFS_STRIDE * k))
              in_sel_next[k] = i_bus.wdata[SEL_W-1:0];
          end
        end
      endcase
    end
    if (i_bus.re)
    begin
      case (i_bus.addr)
        OFS_DEV_LEVEL: rdata_next = DATA_W'(dev_lvl_reg);
        OFS_FB_OFF: rdata_next = DATA_W'(fb_off_reg);
        OFS_FB_ON: rdata_next = DATA_W'(fb_on_reg);
        OFS_PV_SCALE: rdata_next = DATA_W'(scale_reg);
        OFS_SLEEP_THR: rdata_next = DATA_W'(sleep_thr_reg);
        OFS_WAKE_THR: rdata_next = DATA_W'(wake_thr_reg);
        OFS_SLEEP_DLY: rdata_next = DATA_W'(dly_reg);
        OFS_OUT_SEL: rdata_next = DATA_W'({relay_sel_reg, out_sel_reg});
        OFS_STATUS: rdata_next = DATA_W'(stat_reg);
        OFS_MONITOR: rdata_next = DATA_W'(o_feedback_monitor);
        default:
        begin
          for (int k = 0; k < NUM_IN; k++)
          begin
            if (i_bus.addr == ADDR_W'(OFS_IN_SEL_BASE + OFS_STRIDE * k))
              rdata_next = DATA_W'(in_sel_reg[k]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      dev_lvl_reg <= RST_DEV_LVL;
      fb_off_reg <= RST_FB_LVL;
      fb_on_reg <= RST_FB_LVL;
      scale_reg <= RST_SCALE;
      sleep_thr_reg <= RST_HZ;
      wake_thr_reg <= RST_HZ;
      dly_reg <= RST_DLY;
      out_sel_reg <= RST_SEL;
      relay_sel_reg <= RST_SEL;
      for (int k = 0; k < NUM_IN; k++)
        in_sel_reg[k] <= RST_SEL;
      o_rdata <= '0;
    end
    else if (i_ce)
    begin
      dev_lvl_reg <= dev_lvl_next;
      fb_off_reg <= fb_off_next;
      fb_on_reg <= fb_on_next;
      scale_reg <= scale_next;
      sleep_thr_reg <= sleep_thr_next;
      wake_thr_reg <= wake_thr_next;
      dly_reg <= dly_next;
      out_sel_reg <= out_sel_next;
      relay_sel_reg <= relay_sel_next;
      in_sel_reg <= in_sel_next;
      o_rdata <= rdata_next;
    end
  end

  // Deviation and band comparisons are made in hundredths of a percent; sleep and wake compare the command with the Hz thresholds.
  always_comb
  begin
    dev_mag = i_deviation[VAL_W] ? (VAL_W+1)'(-i_deviation) : (VAL_W+1)'(i_deviation);
    dev_lim_val = (VAL_W+1)'(dev_lvl_reg * DEV_LVL_TO_VAL);
    dev_over = dev_mag > dev_lim_val;
    fb_on_val = VAL_W'(fb_on_reg * FB_LVL_TO_VAL);
    fb_off_val = VAL_W'(fb_off_reg * FB_LVL_TO_VAL);
    for (int k = 0; k < NUM_IN; k++)
      clr_mask[k] = (in_sel_reg[k] == SEL_INT_CLEAR);
    clr_level = |(i_terminals & clr_mask);
    cmd_sel = i_pid_enable ? i_pid_cmd : i_freq_cmd;
    sleep_cond = !stat_reg.sleeping && (cmd_sel < VAL_W'(sleep_thr_reg));
    wake_cond = stat_reg.sleeping && (cmd_sel > VAL_W'(wake_thr_reg));
    dly_ticks = CNT_W'(dly_reg * TICKS_PER_TENTH);
  end

  pss_qual #(
    .CNT_W(CNT_W)
  ) u_sleep_wait (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_tick(i_tick),
    .i_cond(sleep_cond),
    .i_limit(dly_ticks),
    .o_done(sleep_go)
  );

  pss_qual #(
    .CNT_W(CNT_W)
  ) u_wake_wait (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_tick(i_tick),
    .i_cond(wake_cond),
    .i_limit(dly_ticks),
    .o_done(wake_go)
  );

  // Flags, terminal routing, integral clear and monitor.
  always_comb
  begin
    stat_next = stat_reg;
    if (i_tick)
    begin
      stat_next.deviation = dev_over;
      if (i_feedback > fb_on_val)
        stat_next.band = 1'b1;
      else if (i_feedback < fb_off_val)
        stat_next.band = 1'b0;
    end
    if (sleep_go)
      stat_next.sleeping = 1'b1;
    else if (wake_go)
      stat_next.sleeping = 1'b0;
    case (out_sel_reg)
      SEL_DEVIATION: dout_next = stat_reg.deviation;
      SEL_BAND: dout_next = stat_reg.band;
      default: dout_next = 1'b0;
    endcase
    case (relay_sel_reg)
      SEL_DEVIATION: relay_next = stat_reg.deviation;
      SEL_BAND: relay_next = stat_reg.band;
      default: relay_next = 1'b0;
    endcase
    clr_prev_next = clr_level;
    clr_pulse_next = clr_level && !clr_prev_reg;
    mon_next = MON_W'(i_feedback) * MON_W'(scale_reg);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      stat_reg <= '0;
      o_dout <= 1'b0;
      o_relay <= 1'b0;
      clr_prev_reg <= 1'b0;
      o_integral_clear <= 1'b0;
      o_feedback_monitor <= '0;
    end
    else if (i_ce)
    begin
      stat_reg <= stat_next;
      o_dout <= dout_next;
      o_relay <= relay_next;
      clr_prev_reg <= clr_prev_next;
      o_integral_clear <= clr_pulse_next;
      o_feedback_monitor <= mon_next;
    end
  end

  assign o_status = stat_reg;
  assign o_run_enable = !stat_reg.sleeping;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_dev_flag;
    (i_ce && i_tick) |=> (o_status.deviation == $past(dev_mag > dev_lim_val));
  endproperty
  a_dev_flag: assert property (p_dev_flag) else $error("deviation flag wrong");

  property p_dev_lvl_range;
    dev_lvl_reg <= DEV_LVL_MAX;
  endproperty
  a_dev_lvl_range: assert property (p_dev_lvl_range) else $error("level over 100");

  property p_route_dev;
    (i_ce && out_sel_reg == SEL_DEVIATION) |=> (o_dout == $past(stat_reg.deviation));
  endproperty
  a_route_dev: assert property (p_route_dev) else $error("output lost deviation");

  property p_route_band;
    (i_ce && relay_sel_reg == SEL_BAND) |=> (o_relay == $past(stat_reg.band));
  endproperty
  a_route_band: assert property (p_route_band) else $error("relay lost band flag");

  property p_monitor;
    i_ce |=> (o_feedback_monitor == MON_W'(MON_W'($past(i_feedback))
      * MON_W'($past(scale_reg))));
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor product wrong");

  property p_int_clear;
    (i_ce && clr_level && !clr_prev_reg) |=> o_integral_clear;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("integral clear missed");

  property p_sleep_enter;
    (i_ce && sleep_go) |=> (o_status.sleeping && !o_run_enable);
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

  property p_wake;
    (i_ce && wake_go) |=> o_run_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not taken");

  property p_hold_band;
    (i_ce && i_tick && i_feedback <= fb_on_val && i_feedback >= fb_off_val)
      |=> $stable(o_status.band);
  endproperty
  a_hold_band: assert property (p_hold_band) else $error("band flag chattered");

  property p_dly_range;
    (dly_reg <= DLY_MAX) && (sleep_thr_reg <= HZ_MAX) && (fb_on_reg <= FB_LVL_MAX);
  endproperty
  a_dly_range: assert property (p_dly_range) else $error("setting out of range");

  c_sleep: cover property (i_ce && sleep_go);
  c_wake: cover property (i_ce && wake_go);
  c_clear: cover property (o_integral_clear);
  c_band: cover property (o_status.band ##1 !o_status.band);

endmodule

//--- rtl/pss_pkg.sv
// Shared types and constants for the PID supervisory and sleep logic.
package pss_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int DEV_LVL_W = 7;
  localparam int FB_LVL_W = 10;
  localparam int SCALE_W = 14;
  localparam int HZ_W = 12;
  localparam int DLY_W = 8;
  localparam int SEL_W = 8;
  localparam int MON_W = 32;

  // Register byte offsets; input selectors sit one word apart from the base.
  localparam logic [ADDR_W-1:0] OFS_DEV_LEVEL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FB_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FB_ON = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PV_SCALE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SLEEP_THR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_WAKE_THR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SLEEP_DLY = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_OUT_SEL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_MONITOR = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_IN_SEL_BASE = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_STRIDE = 8'h04;

  // Field positions inside the output selector word.
  localparam int OUT_SEL_LSB = 0;
  localparam int RELAY_SEL_LSB = 8;

  // Largest accepted settings and the smallest scale; writes above or below them saturate.
  localparam logic [DEV_LVL_W-1:0] DEV_LVL_MAX = 7'h64;
  localparam logic [FB_LVL_W-1:0] FB_LVL_MAX = 10'h3e8;
  localparam logic [SCALE_W-1:0] SCALE_MAX = 14'h270f;
  localparam logic [SCALE_W-1:0] SCALE_MIN = 14'h0001;
  localparam logic [HZ_W-1:0] HZ_MAX = 12'hfa0;
  localparam logic [DLY_W-1:0] DLY_MAX = 8'hff;

  // Reset values.
  localparam logic [SCALE_W-1:0] RST_SCALE = 14'h0064;
  localparam logic [DEV_LVL_W-1:0] RST_DEV_LVL = 7'h00;
  localparam logic [FB_LVL_W-1:0] RST_FB_LVL = 10'h000;
  localparam logic [HZ_W-1:0] RST_HZ = 12'h000;
  localparam logic [DLY_W-1:0] RST_DLY = 8'h00;
  localparam logic [SEL_W-1:0] RST_SEL = 8'h00;

  // Terminal function codes.
  localparam logic [SEL_W-1:0] SEL_DEVIATION = 8'h04;
  localparam logic [SEL_W-1:0] SEL_BAND = 8'h1f;
  localparam logic [SEL_W-1:0] SEL_INT_CLEAR = 8'h18;

  // Conversion of setting units into hundredths of a percent.
  localparam logic [VAL_W-1:0] DEV_LVL_TO_VAL = 16'h0064;
  localparam logic [VAL_W-1:0] FB_LVL_TO_VAL = 16'h000a;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } pss_bus_req_s;

  typedef struct packed {
    logic sleeping;
    logic band;
    logic deviation;
  } pss_status_s;

endpackage

//--- rtl/pss_qual.sv
// Qualifier that reports a condition held continuously for a number of control ticks.
module pss_qual #(
  parameter int CNT_W = 16
) (
  // Clock, reset and freeze
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Condition and length
  input wire logic i_tick,
  input wire logic i_cond,
  input wire logic [CNT_W-1:0] i_limit,
  // Result
  output logic o_done
);
  import pss_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // The counter restarts whenever the condition drops, so a short dip cancels the wait.
  always_comb
  begin
    cnt_next = cnt_reg;
    o_done = 1'b0;
    if (!i_cond)
    begin
      cnt_next = '0;
    end
    else if (i_tick)
    begin
      if (cnt_reg >= i_limit)
      begin
        o_done = i_ce;
        cnt_next = '0;
      end
      else
      begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      cnt_reg <= '0;
    else if (i_ce)
      cnt_reg <= cnt_next;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_drop_clears;
    (i_ce && !i_cond) |=> (cnt_reg == '0);
  endproperty
  a_drop_clears: assert property (p_drop_clears) else $error("wait not abandoned");

  property p_only_on_tick;
    (i_ce && i_cond && !i_tick) |=> $stable(cnt_reg);
  endproperty
  a_only_on_tick: assert property (p_only_on_tick) else $error("count moved off tick");

  property p_done_at_limit;
    o_done |-> (i_tick && i_cond && cnt_reg >= i_limit);
  endproperty
  a_done_at_limit: assert property (p_done_at_limit) else $error("early completion");

endmodule

//--- test/pss_term_model.sv
// Model of the external contacts wired to the digital input terminals.
module pss_term_model #(
  parameter int NUM_IN = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Controller side
  input wire logic i_pid_enable,
  input wire logic [NUM_IN-1:0] i_press,
  // Terminal side
  output logic [NUM_IN-1:0] o_terminals
);
  // Contacts move one cycle after the request and open during reset.
  // While PID runs, the operator leaves the contacts alone, so a clear never lands mid-loop.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_terminals <= '0;
    end
    else if (!i_pid_enable)
    begin
      // No contact is ever given the coast stop function, since sleep stays in use.
      o_terminals <= i_press;
    end
  end
endmodule

//--- test/tb_pss_top.sv
// Self-checking bench for the PID supervisory and sleep logic.
module tb_pss_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pss_pkg::*;
  logic i_clk;
  logic i_resetn;
  logic i_ce;
  pss_bus_req_s bus;
  logic i_tick;
  logic pid_en;
  logic signed [VAL_W:0] dev;
  logic [VAL_W-1:0] fb;
  logic [VAL_W-1:0] pid_cmd;
  logic [VAL_W-1:0] freq_cmd;
  logic [4:0] press;
  logic [4:0] terms;
  logic [DATA_W-1:0] o_rdata;
  logic o_dout;
  logic o_relay;
  logic o_clr;
  logic o_run;
  pss_status_s o_status;
  logic [MON_W-1:0] o_mon;
  logic [70:0] exp_q[$];
  logic [31:0] e_mon;
  logic re_q;
  logic e_dev;
  logic e_band;
  logic e_sleep;
  logic [VAL_W-1:0] sc;
  logic [VAL_W-1:0] fv;
  int fails;
  int checks_done;
  int seed;
  int i;
  int dv[4] = '{1001, 1000, -1001, -1000};
  int feedback_band_flag[4] = '{7001, 5000, 2999, 7000};
  logic [1:0] ex[4] = '{2'b11, 2'b10, 2'b01, 2'b00};

  pss_top #(.TICKS_PER_TENTH(1)) pss_top_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_bus(bus), .o_rdata(o_rdata),
    .i_tick(i_tick), .i_pid_enable(pid_en), .i_deviation(dev), .i_feedback(fb),
    .i_pid_cmd(pid_cmd), .i_freq_cmd(freq_cmd), .i_terminals(terms), .o_dout(o_dout),
    .o_relay(o_relay), .o_integral_clear(o_clr), .o_run_enable(o_run),
    .o_status(o_status), .o_feedback_monitor(o_mon)
  );

  pss_term_model pss_term_model_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_pid_enable(pid_en), .i_press(press),
    .o_terminals(terms)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic stop_test();
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [70:0] seen, input logic [70:0] expv);
    checks_done++;
    if (seen !== expv)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge i_clk);
    bus.we <= 1'b0;
    // An idle edge between transfers keeps each strobe assigned once per step.
    @(posedge i_clk);
  endtask

  // Notes the expected read word with the terminal outputs seen beside it.
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic clr = 1'b0);
    exp_q.push_back({e_mon, e_sleep, e_band, e_dev, e_dev, e_band, ~e_sleep, clr, d});
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge i_clk);
    bus.re <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      i_tick <= 1'b1;
      @(posedge i_clk);
      i_tick <= 1'b0;
      @(posedge i_clk);
    end
  endtask

  function automatic logic [31:0] st();
    return {29'h0, e_sleep, e_band, e_dev};
  endfunction

  // Read data and terminal outputs are judged mid-cycle, once they have settled.
  always @(posedge i_clk) re_q <= bus.re;
  always @(negedge i_clk)
  begin
    if (re_q === 1'b1)
    begin
      if (exp_q.size() == 0)
        fails++;
      else
        check({o_mon, o_status, o_dout, o_relay, o_run, o_clr, o_rdata},
          exp_q.pop_front());
    end
  end

  initial
  begin
    #(40 * 5000);
    fails++;
    stop_test();
  end

  initial
  begin
    seed = 47;
    fails = 0;
    checks_done = 0;
    i_resetn = 1'b0;
    i_ce = 1'b1;
    bus = '0;
    i_tick = 1'b0;
    pid_en = 1'b0;
    dev = '0;
    fb = '0;
    pid_cmd = '0;
    freq_cmd = '0;
    press = '0;
    e_dev = 1'b0;
    e_band = 1'b0;
    e_sleep = 1'b0;
    e_mon = '0;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rd(OFS_PV_SCALE, 32'(RST_SCALE));
    rd(OFS_SLEEP_DLY, 32'h0);
    rd(8'h44, 32'h0);
    wr(OFS_DEV_LEVEL, 32'h000000c8);
    rd(OFS_DEV_LEVEL, 32'h00000064);
    wr(OFS_SLEEP_DLY, 32'h000001ff);
    rd(OFS_SLEEP_DLY, 32'h000000ff);
    wr(OFS_STATUS, 32'h00000007);
    rd(OFS_STATUS, st());
    wr(OFS_PV_SCALE, 32'h00000000);
    rd(OFS_PV_SCALE, 32'(SCALE_MIN));
    repeat (3)
    begin
      sc = 16'(($unsigned($random(seed)) % 9999) + 1);
      fv = 16'($unsigned($random(seed)) % 10001);
      fb <= fv;
      e_mon = 32'(fv) * 32'(sc);
      wr(OFS_PV_SCALE, 32'(sc));
      rd(OFS_PV_SCALE, 32'(sc));
      rd(OFS_MONITOR, e_mon);
    end
    wr(OFS_DEV_LEVEL, 32'h0000000a);
    wr(OFS_FB_OFF, 32'h0000012c);
    wr(OFS_FB_ON, 32'h000002bc);
    wr(OFS_OUT_SEL, 32'h00001f04);
    for (i = 0; i < 4; i++)
    begin
      dev <= 17'(dv[i]);
      fb <= 16'(feedback_band_flag[i]);
      e_mon = 32'(feedback_band_flag[i]) * 32'(sc);
      ticks(1);
      {e_band, e_dev} = ex[i];
      rd(OFS_STATUS, st());
    end
    wr(8'(OFS_IN_SEL_BASE + 2 * OFS_STRIDE), 32'(SEL_INT_CLEAR));
    press <= 5'b00001;
    @(posedge i_clk);
    rd(OFS_STATUS, st(), 1'b0);
    press <= 5'b00101;
    @(posedge i_clk);
    rd(OFS_STATUS, st(), 1'b1);
    press <= 5'b00000;
    @(posedge i_clk);
    press <= 5'b00100;
    @(posedge i_clk);
    rd(OFS_STATUS, st(), 1'b1);
    wr(OFS_SLEEP_DLY, 32'h00000003);
    wr(OFS_SLEEP_THR, 32'h000003e8);
    wr(OFS_WAKE_THR, 32'h000007d0);
    pid_en <= 1'b1;
    pid_cmd <= 16'h01f4;
    ticks(3);
    pid_cmd <= 16'h05dc;
    ticks(1);
    pid_cmd <= 16'h01f4;
    rd(OFS_STATUS, st());
    ticks(3);
    rd(OFS_STATUS, st());
    ticks(1);
    e_sleep = 1'b1;
    rd(OFS_STATUS, st());
    pid_en <= 1'b0;
    freq_cmd <= 16'h09c4;
    ticks(3);
    rd(OFS_STATUS, st());
    ticks(1);
    e_sleep = 1'b0;
    rd(OFS_STATUS, st());
    // A write made while the clock enable is low must not land.
    i_ce <= 1'b0;
    wr(OFS_DEV_LEVEL, 32'h00000032);
    i_ce <= 1'b1;
    rd(OFS_DEV_LEVEL, 32'h0000000a);
    repeat (3) @(posedge i_clk);
    stop_test();
  end
endmodule
